// ===== design/video_receiver_end.sv
// Contract
// - seven serial bits per lane per pixel
// - 10-bit mapping unless 8-bit selected
// - one forwarded clock pair per channel
// - 10-bit lane 0: ..G2
// - 10-bit lane 1: G3..G7, B2, B3
// - 10-bit lane 2: B4..B7, HS, VS, DE
// - 10-bit lane 3: R8,R9,G8,G9,B8,B9,reserved
// - 10-bit lane 4: R0,R1,G0,G1,B0,B1,unused
// - 8-bit lane 0: R0..G0
// - 8-bit lane 1: G1..G5, B0, B1
// - 8-bit lane 2: B2..B5, HS, VS, DE
// - 8-bit lane 3: R6,R7,G6,G7,B6,B7,reserved
// - vsync rising edge starts next frame
// - colour valid only while enable high
// - latch video on pixel clock falling edge
// - components 10 or 8 bits, MSB highest
// - source gamma precompensation needs halftoning
// - source raises hsync within one clock
module video_receiver_end (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    // mode select
    input  wire logic                   mode_8bit,
    // link
    video_link_if.sink                  link,
    // recovered right channel
    output logic [9:0]                  right_red,
    output logic [9:0]                  right_green,
    output logic [9:0]                  right_blue,
    output logic                        right_hsync,
    output logic                        right_vsync,
    output logic                        right_pixel_valid_enable,
    output logic                        right_pixel_strobe,
    output logic                        right_line_start,
    output logic                        right_frame_start,
    output logic [11:0]                 right_pixel_count,
    output logic [11:0]                 right_line_count,
    // recovered left channel
    output logic [9:0]                  left_red,
    output logic [9:0]                  left_green,
    output logic [9:0]                  left_blue,
    output logic                        left_hsync,
    output logic                        left_vsync,
    output logic                        left_pixel_valid_enable,
    output logic                        left_pixel_strobe,
    output logic                        left_line_start,
    output logic                        left_frame_start,
    output logic [11:0]                 left_pixel_count,
    output logic [11:0]                 left_line_count
);

    // ****************************************************************
    // mode
    // ****************************************************************
    logic mode_reg;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_reg <= video_link_pkg::MODE_10BIT;
        end else begin
            mode_reg <= mode_8bit;
        end
    end

    // ****************************************************************
    // per channel recovery
    // ****************************************************************
    video_link_pkg::lane_words_t words      [2];
    video_link_pkg::lane_words_t used_words [2];
    video_link_pkg::video_t      decoded    [2];
    logic [1:0]                  fall;
    video_link_pkg::video_t      video_reg  [2];
    logic [1:0]                  hsync_reg;
    logic [1:0]                  vsync_reg;
    logic [1:0]                  enable_reg;
    logic [1:0]                  strobe_reg;
    logic [1:0]                  line_reg;
    logic [1:0]                  frame_reg;
    logic [11:0]                 pix_cnt_reg  [2];
    logic [11:0]                 line_cnt_reg [2];

    generate
        for (genvar c = 0; c < video_link_pkg::CHANNELS; c++) begin : g_ch
            logic new_hs;
            logic new_vs;
            logic new_de;

            lane_deserializer u_deser (
                .ref_clk    (ref_clk),
                .reset      (reset),
                .clock_pin  (link.pixel_clock[c]),
                .lane_pin   (link.serial_lane[c]),
                .words      (words[c]),
                .fall_pulse (fall[c])
            );

            // reserved slots never reach the decoder
            always_comb begin
                used_words[c]       = words[c];
                used_words[c][3][6] = 1'b0;
                used_words[c][4][6] = 1'b0;
                if (mode_reg == video_link_pkg::MODE_8BIT) begin
                    used_words[c][4] = 7'h00;
                end
            end

            assign decoded[c] = video_link_pkg::decode(used_words[c], mode_reg);
            assign new_hs     = decoded[c].hsync;
            assign new_vs     = decoded[c].vsync;
            assign new_de     = decoded[c].enable;

            // controls latched on every falling edge
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    hsync_reg[c]  <= 1'b0;
                    vsync_reg[c]  <= 1'b0;
                    enable_reg[c] <= 1'b0;
                end else if (fall[c]) begin
                    hsync_reg[c]  <= new_hs;
                    vsync_reg[c]  <= new_vs;
                    enable_reg[c] <= new_de;
                end
            end

            // colour only taken while enable is high
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    video_reg[c] <= '0;
                end else if (fall[c] && new_de) begin
                    video_reg[c] <= decoded[c];
                end
            end

            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    strobe_reg[c] <= 1'b0;
                    line_reg[c]   <= 1'b0;
                    frame_reg[c]  <= 1'b0;
                end else begin
                    strobe_reg[c] <= fall[c] && new_de;
                    line_reg[c]   <= fall[c] && new_hs && !hsync_reg[c];
                    frame_reg[c]  <= fall[c] && new_vs && !vsync_reg[c];
                end
            end

            // position within line and frame
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    pix_cnt_reg[c] <= 12'h000;
                end else if (line_reg[c]) begin
                    pix_cnt_reg[c] <= 12'h000;
                end else if (strobe_reg[c]) begin
                    pix_cnt_reg[c] <= pix_cnt_reg[c] + 12'h001;
                end
            end

            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    line_cnt_reg[c] <= 12'h000;
                end else if (frame_reg[c]) begin
                    line_cnt_reg[c] <= 12'h000;
                end else if (line_reg[c]) begin
                    line_cnt_reg[c] <= line_cnt_reg[c] + 12'h001;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // outputs
    // ****************************************************************
    localparam int R = video_link_pkg::CH_RIGHT;
    localparam int L = video_link_pkg::CH_LEFT;

    assign right_red                = video_reg[R].red;
    assign right_green              = video_reg[R].green;
    assign right_blue               = video_reg[R].blue;
    assign right_hsync              = hsync_reg[R];
    assign right_vsync              = vsync_reg[R];
    assign right_pixel_valid_enable = enable_reg[R];
    assign right_pixel_strobe       = strobe_reg[R];
    assign right_line_start         = line_reg[R];
    assign right_frame_start        = frame_reg[R];
    assign right_pixel_count        = pix_cnt_reg[R];
    assign right_line_count         = line_cnt_reg[R];

    assign left_red                 = video_reg[L].red;
    assign left_green               = video_reg[L].green;
    assign left_blue                = video_reg[L].blue;
    assign left_hsync               = hsync_reg[L];
    assign left_vsync               = vsync_reg[L];
    assign left_pixel_valid_enable  = enable_reg[L];
    assign left_pixel_strobe        = strobe_reg[L];
    assign left_line_start          = line_reg[L];
    assign left_frame_start         = frame_reg[L];
    assign left_pixel_count         = pix_cnt_reg[L];
    assign left_line_count          = line_cnt_reg[L];

endmodule

// ===== design/video_link_pkg.sv
package video_link_pkg;

    // ****************************************************************
    // link framing
    // ****************************************************************
    localparam int CHANNELS       = 2;
    localparam int LANES          = 5;
    localparam int BITS_PER_PIXEL = 7;
    localparam int BIT_CYCLES     = 4;
    localparam int PIXEL_CYCLES   = BITS_PER_PIXEL * BIT_CYCLES;
    localparam int CLK_HIGH_SLOTS = 4;
    localparam int SAMPLE_OFFSET  = 2;
    localparam int CH_RIGHT       = 0;
    localparam int CH_LEFT        = 1;

    // ****************************************************************
    // reset values and modes
    // ****************************************************************
    localparam logic [4:0] CYCLE_RESET = 5'h1f;
    localparam logic [2:0] SLOT_LAST   = 3'h6;
    localparam logic [1:0] BIT_LAST    = 2'h3;
    localparam logic       MODE_10BIT  = 1'b0;
    localparam logic       MODE_8BIT   = 1'b1;

    typedef logic [LANES-1:0][BITS_PER_PIXEL-1:0] lane_words_t;

    typedef struct packed {
        logic [9:0] red;
        logic [9:0] green;
        logic [9:0] blue;
        logic       hsync;
        logic       vsync;
        logic       enable;
    } video_t;

    // ****************************************************************
    // bit mapping, word bit 0 goes out first
    // ****************************************************************
    function automatic lane_words_t encode(input video_t v, input logic mode);
        lane_words_t w;
        if (mode == MODE_8BIT) begin
            w[0] = {v.green[0], v.red[5:0]};
            w[1] = {v.blue[1:0], v.green[5:1]};
            w[2] = {v.enable, v.vsync, v.hsync, v.blue[5:2]};
            w[3] = {1'b0, v.blue[7:6], v.green[7:6], v.red[7:6]};
            w[4] = 7'h00;
        end else begin
            w[0] = {v.green[2], v.red[7:2]};
            w[1] = {v.blue[3:2], v.green[7:3]};
            w[2] = {v.enable, v.vsync, v.hsync, v.blue[7:4]};
            w[3] = {1'b0, v.blue[9:8], v.green[9:8], v.red[9:8]};
            w[4] = {1'b0, v.blue[1:0], v.green[1:0], v.red[1:0]};
        end
        return w;
    endfunction

    function automatic video_t decode(input lane_words_t w, input logic mode);
        video_t v;
        v.hsync  = w[2][4];
        v.vsync  = w[2][5];
        v.enable = w[2][6];
        if (mode == MODE_8BIT) begin
            v.red   = {2'h0, w[3][1:0], w[0][5:0]};
            v.green = {2'h0, w[3][3:2], w[1][4:0], w[0][6]};
            v.blue  = {2'h0, w[3][5:4], w[2][3:0], w[1][6:5]};
        end else begin
            v.red   = {w[3][1:0], w[0][5:0], w[4][1:0]};
            v.green = {w[3][3:2], w[1][4:0], w[0][6], w[4][3:2]};
            v.blue  = {w[3][5:4], w[2][3:0], w[1][6:5], w[4][5:4]};
        end
        return v;
    endfunction

endpackage

// ===== design/video_link_if.sv
interface video_link_if;
    // index 0 right channel, 1 left channel
    logic [1:0]      pixel_clock;
    // lanes 0..4: serial_lane_zero .. serial_lane_four
    logic [1:0][4:0] serial_lane;

    modport source (output pixel_clock, output serial_lane);
    modport sink   (input  pixel_clock, input  serial_lane);
endinterface

// ===== design/lane_deserializer.sv
module lane_deserializer (
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        reset,
    // link pins of one channel
    input  wire logic                        clock_pin,
    input  wire logic [4:0]                  lane_pin,
    // recovered words
    output video_link_pkg::lane_words_t      words,
    output logic                             fall_pulse
);

    // ****************************************************************
    // synchronisers
    // ****************************************************************
    logic       clk_meta_reg;
    logic       clk_sync_reg;
    logic       clk_prev_reg;
    logic [4:0] lane_meta_reg;
    logic [4:0] lane_sync_reg;
    logic [4:0] cycle_reg;
    logic       rise;
    logic       sample;
    logic [2:0] bit_idx;
    video_link_pkg::lane_words_t assemble_reg;
    video_link_pkg::lane_words_t words_reg;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            clk_meta_reg  <= 1'b0;
            clk_sync_reg  <= 1'b0;
            clk_prev_reg  <= 1'b0;
            lane_meta_reg <= 5'h00;
            lane_sync_reg <= 5'h00;
        end else begin
            clk_meta_reg  <= clock_pin;
            clk_sync_reg  <= clk_meta_reg;
            clk_prev_reg  <= clk_sync_reg;
            lane_meta_reg <= lane_pin;
            lane_sync_reg <= lane_meta_reg;
        end
    end

    assign rise       = clk_sync_reg & ~clk_prev_reg;
    assign fall_pulse = ~clk_sync_reg & clk_prev_reg;

    // ****************************************************************
    // bit timing from the forwarded clock
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cycle_reg <= video_link_pkg::CYCLE_RESET;
        end else if (rise) begin
            cycle_reg <= 5'h00;
        end else if (cycle_reg != video_link_pkg::CYCLE_RESET) begin
            cycle_reg <= cycle_reg + 5'h01;
        end
    end

    assign bit_idx = cycle_reg[4:2];
    assign sample  = (cycle_reg[1:0] == 2'(video_link_pkg::SAMPLE_OFFSET))
                   && (int'(cycle_reg) < video_link_pkg::PIXEL_CYCLES);

    // ****************************************************************
    // seven bits per lane per pixel
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            assemble_reg <= '0;
        end else if (sample) begin
            for (int l = 0; l < video_link_pkg::LANES; l++) begin
                assemble_reg[l][bit_idx] <= lane_sync_reg[l];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            words_reg <= '0;
        end else if (sample && bit_idx == video_link_pkg::SLOT_LAST) begin
            for (int l = 0; l < video_link_pkg::LANES; l++) begin
                words_reg[l] <= {lane_sync_reg[l], assemble_reg[l][5:0]};
            end
        end
    end

    assign words = words_reg;

endmodule

// ===== design/video_source_end.sv
module video_source_end (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    // user side
    input  wire logic                   mode_8bit,
    input  video_link_pkg::video_t      pixel_right,
    input  video_link_pkg::video_t      pixel_left,
    output logic                        pixel_taken,
    // link
    video_link_if.source                link
);

    // ****************************************************************
    // dot clock divider
    // ****************************************************************
    logic [1:0]      bit_cycle_reg;
    logic [2:0]      slot_reg;
    logic            load;
    logic            clock_reg;
    logic [1:0][4:0] lane_reg;
    video_link_pkg::lane_words_t words_reg [2];
    video_link_pkg::lane_words_t enc       [2];

    assign load = (bit_cycle_reg == video_link_pkg::BIT_LAST)
               && (slot_reg == video_link_pkg::SLOT_LAST);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bit_cycle_reg <= video_link_pkg::BIT_LAST;
            slot_reg      <= video_link_pkg::SLOT_LAST;
        end else if (load) begin
            bit_cycle_reg <= 2'h0;
            slot_reg      <= 3'h0;
        end else if (bit_cycle_reg == video_link_pkg::BIT_LAST) begin
            bit_cycle_reg <= 2'h0;
            slot_reg      <= slot_reg + 3'h1;
        end else begin
            bit_cycle_reg <= bit_cycle_reg + 2'h1;
        end
    end

    // one clock cycle per pixel, high for the first slots
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            clock_reg <= 1'b0;
        end else if (load) begin
            clock_reg <= 1'b1;
        end else if (bit_cycle_reg == video_link_pkg::BIT_LAST) begin
            clock_reg <= (int'(slot_reg) + 1 < video_link_pkg::CLK_HIGH_SLOTS);
        end
    end

    // ****************************************************************
    // serializer, words held for the whole pixel
    // ****************************************************************
    assign enc[0] = video_link_pkg::encode(pixel_right, mode_8bit);
    assign enc[1] = video_link_pkg::encode(pixel_left, mode_8bit);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            words_reg[0] <= '0;
            words_reg[1] <= '0;
        end else if (load) begin
            words_reg[0] <= enc[0];
            words_reg[1] <= enc[1];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            lane_reg <= '0;
        end else begin
            for (int c = 0; c < video_link_pkg::CHANNELS; c++) begin
                for (int l = 0; l < video_link_pkg::LANES; l++) begin
                    if (load) begin
                        lane_reg[c][l] <= enc[c][l][0];
                    end else if (bit_cycle_reg == video_link_pkg::BIT_LAST) begin
                        lane_reg[c][l] <= words_reg[c][l][slot_reg + 3'h1];
                    end
                end
            end
        end
    end

    assign pixel_taken      = load;
    assign link.pixel_clock = {clock_reg, clock_reg};
    assign link.serial_lane = lane_reg;

endmodule

// ===== tb/video_link_asserts.sv
module video_link_asserts (
    // clock and reset
    input wire logic            ref_clk,
    input wire logic            reset,
    // link wires
    input wire logic [1:0]      pixel_clock,
    input wire logic [1:0][4:0] serial_lane
);
    // ********
    // cycle position since last clock rise
    // ********
    logic       pc_reg;
    logic       run_reg;
    logic [5:0] cyc_reg;
    logic [5:0] pos;

    assign pos = (pixel_clock[0] && !pc_reg) ? 6'h00 : cyc_reg;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pc_reg  <= 1'b0;
            run_reg <= 1'b0;
            cyc_reg <= 6'h00;
        end else begin
            pc_reg  <= pixel_clock[0];
            run_reg <= run_reg | (pixel_clock[0] & ~pc_reg);
            cyc_reg <= pos + 6'h01;
        end
    end

    // ********
    // link rules
    // ********
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_clock_duty: assert property (run_reg |-> pixel_clock[0] == (pos < 6'h10))
        else $error("pixel clock level off its slot");
    a_pixel_period: assert property (run_reg |-> pos < 6'h1c)
        else $error("pixel period longer than seven bits");
    a_high_span: assert property ($rose(pixel_clock[0]) |-> ##16 $fell(pixel_clock[0]))
        else $error("pixel clock high span wrong");
    a_low_span: assert property ($fell(pixel_clock[0]) |->
        !pixel_clock[0] [*8] ##1 !pixel_clock[0] [*4] ##1 pixel_clock[0])
        else $error("pixel clock low span wrong");
    a_channels_share: assert property (pixel_clock[1] == pixel_clock[0])
        else $error("channel clocks differ");
    a_lane_bit_hold: assert property (!$stable(serial_lane) |=> $stable(serial_lane) [*3])
        else $error("lane bit held under four cycles");
    a_reserved_zero: assert property (run_reg && pos >= 6'h18 |->
        serial_lane[0][4:3] == 2'h0 && serial_lane[1][4:3] == 2'h0)
        else $error("reserved slot not zero");
    a_reset_quiet: assert property (disable iff (1'b0)
        reset ##1 reset |-> pixel_clock == 2'h0 && serial_lane == 10'h000)
        else $error("link active in reset");
    a_start_after_reset: assert property ($fell(reset) |->
        pixel_clock == 2'h0 ##1 pixel_clock == 2'h3)
        else $error("link start after reset wrong");

    c_clock_rise: cover property ($rose(pixel_clock[0]));
    c_enable_slot: cover property (run_reg && pos == 6'h18 && serial_lane[0][2]);
    c_lane_four: cover property (run_reg && serial_lane[1][4]);
endmodule

// ===== tb/tb_lvds_video_input_mapper.sv
`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("unexpected at %0t ns: got %h expected %h", $time, (got), (exp)); \
    end \
end

module tb_lvds_video_input_mapper;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   ref_clk;
    logic                   reset;
    logic                   mode_8bit;
    logic                   pixel_taken;
    video_link_pkg::video_t pix [2];
    logic [1:0][9:0]        red;
    logic [1:0][9:0]        green;
    logic [1:0][9:0]        blue;
    logic [1:0]             hs;
    logic [1:0]             vs;
    logic [1:0]             valid_en;
    logic [1:0]             strobe;
    logic [1:0]             line_st;
    logic [1:0]             frame_st;
    logic [1:0][11:0]       lcount;
    logic [1:0][11:0]       pcount;
    int                     err_total;
    int                     total_checks;
    int                     n_strobe [2];
    int                     n_line [2];
    int                     n_frame [2];

    // ********
    // ends and checker
    // ********
    video_link_if link ();

    video_source_end i_video_source_end (.ref_clk(ref_clk), .reset(reset),
        .mode_8bit(mode_8bit), .pixel_right(pix[0]), .pixel_left(pix[1]),
        .pixel_taken(pixel_taken), .link(link));

    video_receiver_end i_video_receiver_end (.ref_clk(ref_clk), .reset(reset),
        .mode_8bit(mode_8bit), .link(link),
        .right_red(red[0]), .right_green(green[0]), .right_blue(blue[0]),
        .right_hsync(hs[0]), .right_vsync(vs[0]), .right_pixel_valid_enable(valid_en[0]),
        .right_pixel_strobe(strobe[0]), .right_line_start(line_st[0]),
        .right_frame_start(frame_st[0]), .right_pixel_count(pcount[0]),
        .right_line_count(lcount[0]),
        .left_red(red[1]), .left_green(green[1]), .left_blue(blue[1]),
        .left_hsync(hs[1]), .left_vsync(vs[1]), .left_pixel_valid_enable(valid_en[1]),
        .left_pixel_strobe(strobe[1]), .left_line_start(line_st[1]),
        .left_frame_start(frame_st[1]), .left_pixel_count(pcount[1]),
        .left_line_count(lcount[1]));

    video_link_asserts chk (.ref_clk(ref_clk), .reset(reset),
        .pixel_clock(link.pixel_clock), .serial_lane(link.serial_lane));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // pulses counted at the falling edge, where they are settled
    always @(negedge ref_clk) begin
        for (int c = 0; c < 2; c++) begin
            n_strobe[c] += int'(strobe[c] === 1'b1);
            n_line[c] += int'(line_st[c] === 1'b1);
            n_frame[c] += int'(frame_st[c] === 1'b1);
        end
    end

    // ********
    // helpers
    // ********
    task automatic wrap_up();
        $display("checks %0d, errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic hung();
        err_total++;
        $display("unexpected at %0t ns: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
        wrap_up();
    endtask

    task automatic wait_px(input int n);
        int i;
        repeat (n) begin
            for (i = 0; i < 40 && pixel_taken !== 1'b1; i++) @(negedge ref_clk);
            if (i == 40) hung();
            @(negedge ref_clk);
        end
    endtask

    task automatic clr();
        n_strobe = '{0, 0};
        n_line = '{0, 0};
        n_frame = '{0, 0};
    endtask

    // lane words from the colour bit mapping
    function automatic logic [4:0][6:0] expw(input video_link_pkg::video_t v, input logic m);
        logic [7:0]      r;
        logic [7:0]      g;
        logic [7:0]      b;
        logic [4:0][6:0] w;
        r = m ? v.red[7:0] : v.red[9:2];
        g = m ? v.green[7:0] : v.green[9:2];
        b = m ? v.blue[7:0] : v.blue[9:2];
        w[0] = {g[0], r[5:0]};
        w[1] = {b[1:0], g[5:1]};
        w[2] = {v.enable, v.vsync, v.hsync, b[5:2]};
        w[3] = {1'b0, b[7:6], g[7:6], r[7:6]};
        w[4] = m ? 7'h00 : {1'b0, v.blue[1:0], v.green[1:0], v.red[1:0]};
        return w;
    endfunction

    // ********
    // scenarios
    // ********
    task automatic check_pixel(input logic m, input video_link_pkg::video_t vr);
        logic [1:0][4:0][6:0]   got;
        logic [4:0][6:0]        ex [2];
        video_link_pkg::video_t v [2];
        int                     i;
        v[0] = vr;
        v[1] = ~vr;
        v[1].enable = 1'b1;
        v[1].vsync = v[1].hsync;
        mode_8bit = m;
        pix = v;
        wait_px(3);
        for (i = 0; i < 40 && link.pixel_clock[0] !== 1'b0; i++) @(negedge ref_clk);
        for (i = 0; i < 40 && link.pixel_clock[0] !== 1'b1; i++) @(negedge ref_clk);
        if (i == 40) hung();
        for (int k = 0; k < 7; k++) begin
            repeat ((k == 0) ? 1 : 4) @(negedge ref_clk);
            for (int l = 0; l < 5; l++) begin
                got[0][l][k] = link.serial_lane[0][l];
                got[1][l][k] = link.serial_lane[1][l];
            end
        end
        for (int c = 0; c < 2; c++) begin
            ex[c] = expw(v[c], m);
            for (int l = 0; l < 5; l++) begin
                `CHK(got[c][l], ex[c][l])
            end
            if (m) begin
                v[c].red[9:8] = 2'h0;
                v[c].green[9:8] = 2'h0;
                v[c].blue[9:8] = 2'h0;
            end
            `CHK(red[c], v[c].red)
            `CHK(green[c], v[c].green)
            `CHK(blue[c], v[c].blue)
            `CHK({hs[c], vs[c], valid_en[c]}, {v[c].hsync, v[c].vsync, v[c].enable})
        end
    endtask

    task automatic check_enable();
        wait_px(3);
        clr();
        wait_px(4);
        `CHK(n_strobe[0], 4)
        `CHK(n_strobe[1], 4)
        pix[0] = {10'h3ff, 10'h000, 10'h155, 3'h0};
        pix[1] = {10'h0f0, 10'h30c, 10'h2aa, 3'h0};
        wait_px(3);
        clr();
        wait_px(4);
        `CHK(n_strobe[0] + n_strobe[1], 0)
        `CHK(red[0], 10'h14a)
        `CHK(valid_en, 2'h0)
        pix[0].enable = 1'b1;
        pix[1].enable = 1'b1;
    endtask

    task automatic check_sync();
        logic [1:0][11:0] lines;
        wait_px(3);
        clr();
        lines = lcount;
        pix[0].hsync = 1'b1;
        pix[1].hsync = 1'b1;
        wait_px(2);
        pix[0].hsync = 1'b0;
        pix[1].hsync = 1'b0;
        wait_px(3);
        `CHK({n_line[0], n_line[1], n_frame[0]}, {32'h1, 32'h1, 32'h0})
        `CHK(lcount, {lines[1] + 12'h001, lines[0] + 12'h001})
        // pixel carrying the hsync edge restarts the count, two follow
        `CHK(pcount, {12'h002, 12'h002})
        clr();
        pix[0] = {pix[0].red, pix[0].green, pix[0].blue, 3'h7};
        pix[1] = {pix[1].red, pix[1].green, pix[1].blue, 3'h7};
        wait_px(2);
        pix[0] = {pix[0].red, pix[0].green, pix[0].blue, 3'h1};
        pix[1] = {pix[1].red, pix[1].green, pix[1].blue, 3'h1};
        wait_px(3);
        `CHK({n_frame[0], n_frame[1]}, {32'h1, 32'h1})
        `CHK({n_line[0], n_line[1]}, {32'h1, 32'h1})
    endtask

    initial begin
        #1000000;
        hung();
    end

    initial begin
        err_total = 0;
        total_checks = 0;
        reset = 1'b1;
        mode_8bit = 1'b0;
        pix = '{33'h0, 33'h0};
        clr();
        repeat (4) @(negedge ref_clk);
        reset = 1'b0;
        for (int m = 0; m < 2; m++) begin
            // plain colour codes, no inverse gamma, so no halftoning owed
            check_pixel(m[0], {10'h2b5, 10'h1ca, 10'h36c, 3'h7});
            check_pixel(m[0], {10'h14a, 10'h235, 10'h093, 3'h1});
        end
        check_pixel(1'b0, {10'h14a, 10'h235, 10'h093, 3'h1});
        check_enable();
        check_sync();
        wrap_up();
    end
endmodule
